// ===== design/sram_host_regs.svh
// timing constants and widths for the static memory host controller
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH

`define ADDR_W            16
`define DATA_W            16
`define CLK_PERIOD_NS     40
// device figures, fastest grade, in ns
`define T_ACCESS_NS       10
`define T_OE_VALID_NS     5
`define T_LANE_VALID_NS   5
`define T_RELEASE_NS      5
`define T_ADDR_END_NS     7
`define T_CS_END_NS       7
`define T_LANE_END_NS     7
`define T_DATA_SETUP_NS   5
`define T_WRITE_PULSE_NS  7
// whole cycles: least times round up, waits for the device round up too
`define CYC_UP(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC     `CYC_UP(`T_ACCESS_NS)
`define RELEASE_CYC       `CYC_UP(`T_RELEASE_NS)
`define WRITE_PULSE_CYC   `CYC_UP(`T_RELEASE_NS + `T_DATA_SETUP_NS)
`define CNT_W             3

`endif

// ===== design/sram_host_pkg.sv
// types for the static memory host controller
package sram_host_pkg;
  typedef struct packed {
    logic        write;
    logic [1:0]  lane_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } req_s;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic upper_lane_strobe_n;
    logic lower_lane_strobe_n;
  } strobes_s;

  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_read    = 3'b001,
    st_capture = 3'b011,
    st_wsetup  = 3'b100,
    st_wpulse  = 3'b110,
    st_recover = 3'b010
  } state_e;
endpackage

// ===== design/sram_host_timer.sv
// down counter for cycle waits
`include "sram_host_regs.svh"
module sram_host_timer (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic              load,
  input  wire logic [`CNT_W-1:0] value,
  // status
  output logic                   done
);
  logic [`CNT_W-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - `CNT_W'(1);
    end
  end

  assign done = (count == '0) && !load;
endmodule

// ===== design/sram_host.sv
// host controller for a 64K x 16 asynchronous static memory with byte lanes
`include "sram_host_regs.svh"
module sram_host (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // user request
  input  wire logic                     req_valid,
  input  sram_host_pkg::req_s           req,
  output logic                          req_ready,
  // user answer
  output logic                          rsp_valid,
  output logic [`DATA_W-1:0]            rsp_rdata,
  // memory control pins
  output logic [`ADDR_W-1:0]            word_addr,
  output sram_host_pkg::strobes_s       strobes,
  // shared data bus pins
  input  wire logic [`DATA_W-1:0]       shared_data_bus_in,
  output logic [`DATA_W-1:0]            shared_data_bus_out,
  output logic                          shared_data_bus_oe
);
  sram_host_pkg::state_e state;
  sram_host_pkg::state_e next_state;
  logic [`DATA_W-1:0]    bus_meta;
  logic [`DATA_W-1:0]    bus_sync;
  logic                  timer_load;
  logic [`CNT_W-1:0]     timer_value;
  logic                  timer_done;
  logic                  take;
  logic [1:0]            lanes;
  sram_host_pkg::strobes_s next_strobes;
  logic [1:0]            held_lanes_n;
  logic [1:0]            next_lanes_n;
  logic                  access_on;
  logic                  write_low;
  logic [`CNT_W-1:0]     read_wait;
  logic [`CNT_W-1:0]     release_wait;
  logic [`CNT_W-1:0]     pulse_wait;

  // two-stage sampling of the pin data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_meta <= '0;
      bus_sync <= '0;
    end else begin
      bus_meta <= shared_data_bus_in;
      bus_sync <= bus_meta;
    end
  end

  // one shared timer for read wait, write pulse and recovery
  sram_host_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (timer_load),
    .value (timer_value),
    .done  (timer_done)
  );

  // a request is refused until ready has come up after reset
  assign take  = (state == sram_host_pkg::st_idle) && req_valid && req_ready;
  assign lanes = req.lane_en;

  // wait lengths in whole clock cycles, rounded up
  assign read_wait    = `CNT_W'(`READ_WAIT_CYC + 2);
  assign release_wait = `CNT_W'(`RELEASE_CYC);
  assign pulse_wait   = `CNT_W'(`WRITE_PULSE_CYC);

  // next state
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = '0;
    unique case (state)
      sram_host_pkg::st_idle: begin
        if (take && req.write) begin
          next_state = sram_host_pkg::st_wsetup;
        end else if (take) begin
          next_state  = sram_host_pkg::st_read;
          timer_load  = 1'b1;
          // read wait plus two synchroniser stages
          timer_value = read_wait;
        end
      end
      sram_host_pkg::st_read: begin
        if (timer_done) begin
          next_state = sram_host_pkg::st_capture;
        end
      end
      sram_host_pkg::st_capture: begin
        next_state  = sram_host_pkg::st_recover;
        timer_load  = 1'b1;
        timer_value = release_wait;
      end
      sram_host_pkg::st_wsetup: begin
        next_state  = sram_host_pkg::st_wpulse;
        timer_load  = 1'b1;
        timer_value = pulse_wait;
      end
      sram_host_pkg::st_wpulse: begin
        if (timer_done) begin
          next_state = sram_host_pkg::st_recover;
        end
      end
      sram_host_pkg::st_recover: begin
        if (timer_done) begin
          next_state = sram_host_pkg::st_idle;
        end
      end
      default: next_state = sram_host_pkg::st_idle;
    endcase
  end

  // read states: select, lanes and output enable low
  function automatic logic is_read(input sram_host_pkg::state_e s);
    return (s == sram_host_pkg::st_read) || (s == sram_host_pkg::st_capture);
  endfunction

  // write states: select and lanes low, host drives the bus
  function automatic logic is_write(input sram_host_pkg::state_e s);
    return (s == sram_host_pkg::st_wsetup) || (s == sram_host_pkg::st_wpulse);
  endfunction

  // lane strobes follow the request at launch and hold until the access ends
  assign held_lanes_n = {strobes.upper_lane_strobe_n, strobes.lower_lane_strobe_n};
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign next_lanes_n[g] = take ? ~lanes[g] : held_lanes_n[g];
  end
  assign access_on = is_read(next_state) || is_write(next_state);
  assign write_low = (next_state == sram_host_pkg::st_wpulse);

  // pin levels for the next state
  always_comb begin
    next_strobes = '1;
    if (access_on) begin
      next_strobes.chip_select_n       = 1'b0;
      next_strobes.upper_lane_strobe_n = next_lanes_n[1];
      next_strobes.lower_lane_strobe_n = next_lanes_n[0];
    end
    if (is_read(next_state)) begin
      next_strobes.output_enable_n = 1'b0;
    end
    // output enable high in writes, strobe falls a cycle after select and lanes
    if (write_low) begin
      next_strobes.write_strobe_n = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= sram_host_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // control pins and handshake from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobes   <= '1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      strobes   <= next_strobes;
      req_ready <= (next_state == sram_host_pkg::st_idle);
      rsp_valid <= (state == sram_host_pkg::st_capture);
    end
  end

  // address and write data launch with the select fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_addr           <= '0;
      shared_data_bus_out <= '0;
    end else if (take) begin
      word_addr           <= req.addr;
      shared_data_bus_out <= req.wdata;
    end
  end

  // read data taken from the synchroniser while the lanes still drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_rdata <= '0;
    end else if (state == sram_host_pkg::st_capture) begin
      rsp_rdata <= bus_sync;
    end
  end

  // drive data only in writes, read bus released by then
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shared_data_bus_oe <= 1'b0;
    end else begin
      shared_data_bus_oe <= is_write(next_state);
    end
  end
endmodule

// ===== dv/sram_host_props.sv
// pin-level checks for the static memory host controller
`include "sram_host_regs.svh"
module sram_host_props (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                req_ready,
  input wire logic                rsp_valid,
  input wire logic [`ADDR_W-1:0]  word_addr,
  input sram_host_pkg::strobes_s  strobes,
  input wire logic [`DATA_W-1:0]  shared_data_bus_out,
  input wire logic                shared_data_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire cs_n = strobes.chip_select_n;
  wire oe_n = strobes.output_enable_n;
  wire we_n = strobes.write_strobe_n;
  wire oe   = shared_data_bus_oe;
  wire [1:0] lanes = {strobes.upper_lane_strobe_n, strobes.lower_lane_strobe_n};
  a_read_no_strobe: assert property (!oe_n |-> we_n) else $error("strobe low in read");
  a_addr_held: assert property (!cs_n && $past(!cs_n) |-> $stable(word_addr))
    else $error("address moved in access");
  a_cs_before_we: assert property ($fell(we_n) |-> $past(!cs_n)) else $error("select late");
  a_lane_before_we: assert property ($fell(we_n) |-> $stable(lanes)) else $error("lanes late");
  a_data_setup: assert property (!we_n |-> oe && $past(oe) && $stable(shared_data_bus_out))
    else $error("write data not set up");
  a_pulse_oe_high: assert property (!we_n |-> oe_n) else $error("output enable low in write");
  a_no_fight: assert property (oe |-> oe_n && $past(oe_n)) else $error("bus contention");
  a_read_wait: assert property ($fell(oe_n) |-> !oe_n [*3]) else $error("read too short");
  a_rsp_from_read: assert property (rsp_valid |-> $past(!oe_n)) else $error("answer without read");
  a_idle_float: assert property (req_ready |-> cs_n && !oe) else $error("idle not released");
  cover property (rsp_valid);
  cover property ($fell(we_n));
  cover property (rsp_valid ##[1:8] $fell(we_n));
endmodule

// ===== dv/sram_model.sv
// behavioural model of the asynchronous static memory
module sram_model (
  input sram_host_pkg::strobes_s strobes,
  input wire logic [15:0]        word_addr,
  input wire logic [15:0]        bus,
  output logic [15:0]            dev_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  logic [15:0] last = 16'h0000;
  logic [15:0] q;
  logic [1:0]  drv;
  wire sel = !strobes.chip_select_n;
  wire [1:0] ln = ~{strobes.upper_lane_strobe_n, strobes.lower_lane_strobe_n};
  wire rd = sel && !strobes.output_enable_n && strobes.write_strobe_n;
  // drive after 4 ns, release within 4 ns
  assign #4 drv = rd ? ln : 2'b00;
  assign #4 q = mem[word_addr];
  // a floating lane shows the inverse of the last level
  always @(strobes) last = bus;
  assign dev_level = {drv[1] ? q[15:8] : ~last[15:8], drv[0] ? q[7:0] : ~last[7:0]};
  always @* begin
    if (sel && !strobes.write_strobe_n) begin
      if (ln[1]) mem[word_addr][15:8] = bus[15:8];
      if (ln[0]) mem[word_addr][7:0] = bus[7:0];
    end
  end
endmodule

// ===== dv/testbench.sv
// testbench for the static memory host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, req_valid = 0;
  sram_host_pkg::req_s req = '0;
  logic req_ready, rsp_valid, shared_data_bus_oe;
  logic [15:0] rsp_rdata, word_addr, shared_data_bus_out, dev_level, bus, q;
  sram_host_pkg::strobes_s strobes;
  int n_fail = 0, compares = 0;
  always #20 clk = ~clk;
  assign bus = shared_data_bus_oe ? shared_data_bus_out : dev_level;
  sram_host u_sram_host (.clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .word_addr,
    .strobes, .shared_data_bus_in(bus), .shared_data_bus_out, .shared_data_bus_oe);
  sram_model u_sram_model (.strobes, .word_addr, .bus, .dev_level);
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      end_of_test;
    end
  endtask
  task access(input logic w, input logic [1:0] ln, input logic [15:0] a, input logic [15:0] d);
    int i;
    logic t;
    @(negedge clk);
    req_valid = 1;
    req = '{w, ln, a, d};
    i = 0;
    do begin @(posedge clk); t = req_ready; i++; end while (t !== 1'b1 && i < 50);
    tmo(t);
    @(negedge clk);
    req_valid = 0;
    if (!w) begin
      i = 0;
      do begin @(negedge clk); i++; end while (rsp_valid !== 1'b1 && i < 20);
      tmo(rsp_valid);
      q = rsp_rdata;
    end
  endtask
  task t_word;
    access(1, 2'b11, 16'h0001, 16'h1234);
    access(0, 2'b11, 16'h0001, 16'h0000);
    check("word", q, 16'h1234);
    $display("test word done");
  endtask
  task t_lanes;
    access(1, 2'b11, 16'h0002, 16'haaaa);
    access(1, 2'b10, 16'h0002, 16'h3c55);
    access(0, 2'b01, 16'h0002, 16'h0000);
    check("lower lane", {8'h00, q[7:0]}, 16'h00aa);
    access(0, 2'b10, 16'h0002, 16'h0000);
    check("upper lane", {q[15:8], 8'h00}, 16'h3c00);
    access(0, 2'b11, 16'h0002, 16'h0000);
    check("merged", q, 16'h3caa);
    $display("test lanes done");
  endtask
  task t_none;
    access(1, 2'b00, 16'h0001, 16'hffff);
    access(0, 2'b11, 16'h0001, 16'h0000);
    check("no lane", q, 16'h1234);
    $display("test no lane done");
  endtask
  task t_edges;
    access(1, 2'b11, 16'hffff, 16'hbeef);
    access(1, 2'b11, 16'h0000, 16'h0f0f);
    access(0, 2'b11, 16'hffff, 16'h0000);
    check("top address", q, 16'hbeef);
    access(0, 2'b11, 16'h0000, 16'h0000);
    check("bottom address", q, 16'h0f0f);
    $display("test edges done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_word;
    t_lanes;
    t_none;
    t_edges;
    end_of_test;
  end
endmodule
bind sram_host sram_host_props u_sram_host_props (.clk, .rst, .req_ready, .rsp_valid, .word_addr, .strobes,
  .shared_data_bus_out, .shared_data_bus_oe);
